// >>> adcseq_top.v
// Purpose: APB-controlled sequencer for a 12-bit successive-approximation converter.
// Assumes: Comparator input is synchronous to ref_clk; analog parts are external.
// Notes:   One wait state on every APB access; unmapped addresses answer pslverr.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "adcseq_defines.vh"

module adcseq_top
(
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        cmpAbove,
    output reg  [11:0] dacTrial,
    output reg         convPowerOn,
    output reg         sampleActive,
    output reg         convertActive,
    output reg         extChanConnect,
    output reg  [3:0]  extChanSelect,
    output reg  [3:0]  internalSelect,
    output reg  [1:0]  refSourceSelect,
    output reg         defaultRefDisconnect,
    output reg         irq
);

    // Software-visible configuration
    reg  [3:0]  chanSel_ff;
    reg         formatSel_ff;
    reg         powerEn_ff;
    reg         start_ff;
    reg         startPrev_ff;
    reg  [2:0]  divSel_ff;
    reg  [1:0]  refSel_ff;
    reg  [2:0]  srcSel_ff;
    reg         refOff_ff;
    reg         doneFlag_ff;
    reg         doneMask_ff;
    reg         globalIe_ff;

    // Sequencer state
    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [3:0]  clkCnt_ff;
    reg  [3:0]  nxt_clkCnt;
    reg  [11:0] trial_ff;
    reg  [11:0] nxt_trial;
    reg  [11:0] bitMask_ff;
    reg  [11:0] nxt_bitMask;
    reg  [11:0] result_ff;
    reg  [11:0] nxt_result;
    reg         busy_ff;
    reg         nxt_busy;
    reg         doneEvent;

    wire        convTick;
    wire        accessPhase;
    wire        wrEn;
    wire        rdEn;
    wire        startLaunch;
    wire        holdReset;
    wire [11:0] keptTrial;
    wire [7:0]  resHigh;
    wire [7:0]  resLow;
    reg  [31:0] nxt_rdata;
    reg         nxt_err;

    // APB decode; the write lands on the edge that samples pready high
    assign accessPhase = psel && penable;
    assign wrEn        = accessPhase && pready && pwrite;
    assign rdEn        = accessPhase && !pready && !pwrite;

    // Launch on the falling edge of the start bit; high level holds in reset
    assign holdReset   = start_ff || !powerEn_ff;
    assign startLaunch = startPrev_ff && !start_ff && powerEn_ff;

    adcseq_clk_div u_div
    (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clear   (holdReset || startLaunch),
        .sel     (divSel_ff),
        .tick    (convTick)
    );

    // Bit kept when comparator says input lies at or above the trial level
    assign keptTrial = cmpAbove ? trial_ff : (trial_ff & ~bitMask_ff);

    // Sequencer: four sampling clocks, then one bit decided per clock for twelve
    always @*
    begin
        nxt_state   = state_ff;
        nxt_clkCnt  = clkCnt_ff;
        nxt_trial   = trial_ff;
        nxt_bitMask = bitMask_ff;
        nxt_result  = result_ff;
        nxt_busy    = busy_ff;
        doneEvent   = 1'b0;
        if (holdReset)
        begin
            nxt_state   = `ADCSEQ_ST_IDLE;
            nxt_clkCnt  = 4'h0;
            nxt_trial   = 12'h000;
            nxt_bitMask = 12'h000;
            nxt_busy    = 1'b0;
        end
        else if (startLaunch)
        begin
            nxt_state   = `ADCSEQ_ST_SAMPLE;
            nxt_clkCnt  = 4'h0;
            nxt_trial   = 12'h000;
            nxt_bitMask = 12'h000;
            nxt_busy    = 1'b1;
        end
        else if (convTick)
        begin
            case (state_ff)
                `ADCSEQ_ST_IDLE:
                begin
                    nxt_state = `ADCSEQ_ST_IDLE;
                end
                `ADCSEQ_ST_SAMPLE:
                begin
                    if (clkCnt_ff == (`ADCSEQ_SAMPLE_CLKS - 4'h1))
                    begin
                        nxt_state   = `ADCSEQ_ST_CONVERT;
                        nxt_clkCnt  = 4'h0;
                        nxt_trial   = `ADCSEQ_RES_MSB_TRIAL;
                        nxt_bitMask = `ADCSEQ_RES_MSB_TRIAL;
                    end
                    else
                    begin
                        nxt_clkCnt = clkCnt_ff + 4'h1;
                    end
                end
                `ADCSEQ_ST_CONVERT:
                begin
                    if (clkCnt_ff == (`ADCSEQ_CONV_CLKS - 4'h1))
                    begin
                        nxt_state   = `ADCSEQ_ST_IDLE;
                        nxt_clkCnt  = 4'h0;
                        nxt_result  = keptTrial;
                        nxt_trial   = 12'h000;
                        nxt_bitMask = 12'h000;
                        nxt_busy    = 1'b0;
                        doneEvent   = 1'b1;
                    end
                    else
                    begin
                        nxt_clkCnt  = clkCnt_ff + 4'h1;
                        nxt_bitMask = bitMask_ff >> 1;
                        nxt_trial   = keptTrial | (bitMask_ff >> 1);
                    end
                end
                default:
                begin
                    nxt_state = `ADCSEQ_ST_IDLE;
                    nxt_busy  = 1'b0;
                end
            endcase
        end
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff     <= `ADCSEQ_ST_IDLE;
            clkCnt_ff    <= 4'h0;
            trial_ff     <= 12'h000;
            bitMask_ff   <= 12'h000;
            result_ff    <= 12'h000;
            busy_ff      <= 1'b0;
            startPrev_ff <= 1'b0;
        end
        else
        begin
            state_ff     <= nxt_state;
            clkCnt_ff    <= nxt_clkCnt;
            trial_ff     <= nxt_trial;
            bitMask_ff   <= nxt_bitMask;
            result_ff    <= nxt_result;
            busy_ff      <= nxt_busy;
            startPrev_ff <= start_ff;
        end
    end

    // Result placement: format 0 left-justifies, format 1 right-justifies
    assign resHigh = formatSel_ff ? {4'h0, result_ff[11:8]} : result_ff[11:4];
    assign resLow  = formatSel_ff ? result_ff[7:0] : {result_ff[3:0], 4'h0};

    // Register writes; only the done flag is cleared by writing one
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chanSel_ff   <= `ADCSEQ_RST_CHAN;
            formatSel_ff <= 1'b0;
            powerEn_ff   <= 1'b0;
            start_ff     <= 1'b0;
            divSel_ff    <= `ADCSEQ_RST_DIV;
            refSel_ff    <= `ADCSEQ_RST_REF;
            srcSel_ff    <= `ADCSEQ_RST_SRC;
            refOff_ff    <= 1'b0;
            doneMask_ff  <= 1'b0;
            globalIe_ff  <= 1'b0;
        end
        else if (wrEn)
        begin
            case (paddr)
                `ADCSEQ_OFS_CTRL0:
                begin
                    chanSel_ff   <= pwdata[`ADCSEQ_C0_CHAN_MSB:`ADCSEQ_C0_CHAN_LSB];
                    formatSel_ff <= pwdata[`ADCSEQ_C0_FORMAT];
                    powerEn_ff   <= pwdata[`ADCSEQ_C0_POWER];
                    start_ff     <= pwdata[`ADCSEQ_C0_START];
                end
                `ADCSEQ_OFS_CTRL1:
                begin
                    divSel_ff <= pwdata[`ADCSEQ_C1_DIV_MSB:`ADCSEQ_C1_DIV_LSB];
                    refSel_ff <= pwdata[`ADCSEQ_C1_REF_MSB:`ADCSEQ_C1_REF_LSB];
                    srcSel_ff <= pwdata[`ADCSEQ_C1_SRC_MSB:`ADCSEQ_C1_SRC_LSB];
                    refOff_ff <= pwdata[`ADCSEQ_C1_REFOFF];
                end
                `ADCSEQ_OFS_INT_MASK:
                begin
                    doneMask_ff <= pwdata[`ADCSEQ_INT_DONE];
                end
                `ADCSEQ_OFS_INT_GLOBAL:
                begin
                    globalIe_ff <= pwdata[`ADCSEQ_INT_DONE];
                end
                default:
                begin
                    chanSel_ff <= chanSel_ff;
                end
            endcase
        end
    end

    // Sticky done flag; a completion in the clearing cycle wins over the clear
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            doneFlag_ff <= 1'b0;
        else if (doneEvent)
            doneFlag_ff <= 1'b1;
        else if (wrEn && (paddr == `ADCSEQ_OFS_INT_STAT) && pwdata[`ADCSEQ_INT_DONE])
            doneFlag_ff <= 1'b0;
    end

    // Read mux; unmapped addresses read zero and flag an error
    always @*
    begin
        nxt_rdata = 32'h0000_0000;
        nxt_err   = 1'b0;
        case (paddr)
            `ADCSEQ_OFS_CTRL0:
            begin
                nxt_rdata[`ADCSEQ_C0_CHAN_MSB:`ADCSEQ_C0_CHAN_LSB] = chanSel_ff;
                nxt_rdata[`ADCSEQ_C0_FORMAT] = formatSel_ff;
                nxt_rdata[`ADCSEQ_C0_POWER]  = powerEn_ff;
                nxt_rdata[`ADCSEQ_C0_BUSY]   = busy_ff;
                nxt_rdata[`ADCSEQ_C0_START]  = start_ff;
            end
            `ADCSEQ_OFS_CTRL1:
            begin
                nxt_rdata[`ADCSEQ_C1_DIV_MSB:`ADCSEQ_C1_DIV_LSB] = divSel_ff;
                nxt_rdata[`ADCSEQ_C1_REF_MSB:`ADCSEQ_C1_REF_LSB] = refSel_ff;
                nxt_rdata[`ADCSEQ_C1_SRC_MSB:`ADCSEQ_C1_SRC_LSB] = srcSel_ff;
                nxt_rdata[`ADCSEQ_C1_REFOFF] = refOff_ff;
            end
            `ADCSEQ_OFS_RES_HIGH:
            begin
                nxt_rdata[7:0] = resHigh;
            end
            `ADCSEQ_OFS_RES_LOW:
            begin
                nxt_rdata[7:0] = resLow;
            end
            `ADCSEQ_OFS_INT_STAT:
            begin
                nxt_rdata[`ADCSEQ_INT_DONE] = doneFlag_ff;
            end
            `ADCSEQ_OFS_INT_MASK:
            begin
                nxt_rdata[`ADCSEQ_INT_DONE] = doneMask_ff;
            end
            `ADCSEQ_OFS_INT_GLOBAL:
            begin
                nxt_rdata[`ADCSEQ_INT_DONE] = globalIe_ff;
            end
            default:
            begin
                nxt_err = 1'b1;
            end
        endcase
    end

    // Registered answer: pready rises one cycle into the access phase
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= accessPhase && !pready;
            pslverr <= accessPhase && !pready && nxt_err;
            if (rdEn)
                prdata <= nxt_rdata;
        end
    end

    // Analog controls forced off, and defaultRefDisconnect forced high, while the power enable is clear
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            convPowerOn          <= 1'b0;
            sampleActive         <= 1'b0;
            convertActive        <= 1'b0;
            dacTrial             <= 12'h000;
            extChanConnect       <= 1'b0;
            extChanSelect        <= 4'h0;
            internalSelect       <= 4'h0;
            refSourceSelect      <= 2'h0;
            defaultRefDisconnect <= 1'b0;
        end
        else
        begin
            convPowerOn     <= powerEn_ff;
            sampleActive    <= (nxt_state == `ADCSEQ_ST_SAMPLE);
            convertActive   <= (nxt_state == `ADCSEQ_ST_CONVERT);
            dacTrial        <= nxt_trial;
            extChanSelect   <= powerEn_ff ? chanSel_ff : 4'h0;
            refSourceSelect <= powerEn_ff ? refSel_ff : 2'h0;
            // Software must set the disconnect when the supply is the reference
            defaultRefDisconnect <= refOff_ff || !powerEn_ff;
            extChanConnect  <= 1'b0;
            internalSelect  <= 4'h0;
            if (powerEn_ff)
            begin
                case (srcSel_ff)
                    `ADCSEQ_SRC_BANDGAP: internalSelect <= 4'h1;
                    `ADCSEQ_SRC_AMP_OUT: internalSelect <= 4'h2;
                    `ADCSEQ_SRC_AMP_INP: internalSelect <= 4'h4;
                    `ADCSEQ_SRC_GND:     internalSelect <= 4'h8;
                    default:             extChanConnect <= 1'b1;
                endcase
            end
        end
    end

    // Level interrupt: needs the global enable and the done mask bit
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= doneFlag_ff && doneMask_ff && globalIe_ff;
    end

endmodule

// >>> adcseq_defines.vh
// Purpose: Constants for the conversion sequencer: offsets, fields, resets, states.
// Assumes: 32-bit APB, byte addresses, one register per aligned word.
// Notes:   Summary of operation
// Summary of operation
// - Sample four clocks, then convert twelve.
// - Converter clock divided from system clock.
// - Converter usable only with power enable set.
// - Power enable clear switches analog circuitry off.
// - Source field picks pin or internal signal.
// - Reference select; supply needs default ref disconnect.
// - Format bit places result across two bytes.
// - Start pulse low-high-low launches a conversion.
// - Busy high during conversion, result then readable.
// - Unsigned 12-bit code, full scale fff.
// - Source codes map to pin, bandgap, amplifier, ground.
// - Divider select gives divide by 1 to 128.
// - Busy set on start; completion raises request flag.
`ifndef ADCSEQ_DEFINES_VH
`define ADCSEQ_DEFINES_VH

// Register byte offsets
`define ADCSEQ_OFS_CTRL0      8'h00
`define ADCSEQ_OFS_CTRL1      8'h04
`define ADCSEQ_OFS_RES_HIGH   8'h08
`define ADCSEQ_OFS_RES_LOW    8'h0c
`define ADCSEQ_OFS_INT_STAT   8'h10
`define ADCSEQ_OFS_INT_MASK   8'h14
`define ADCSEQ_OFS_INT_GLOBAL 8'h18

// First control register fields
`define ADCSEQ_C0_CHAN_LSB    0
`define ADCSEQ_C0_CHAN_MSB    3
`define ADCSEQ_C0_FORMAT      4
`define ADCSEQ_C0_POWER       5
`define ADCSEQ_C0_BUSY        6
`define ADCSEQ_C0_START       7

// Second control register fields
`define ADCSEQ_C1_DIV_LSB     0
`define ADCSEQ_C1_DIV_MSB     2
`define ADCSEQ_C1_REF_LSB     3
`define ADCSEQ_C1_REF_MSB     4
`define ADCSEQ_C1_SRC_LSB     5
`define ADCSEQ_C1_SRC_MSB     7
`define ADCSEQ_C1_REFOFF      8

// Interrupt bit position (status, mask and global share bit 0)
`define ADCSEQ_INT_DONE       0

// Reset values
`define ADCSEQ_RST_CHAN       4'h0
`define ADCSEQ_RST_DIV        3'h0
`define ADCSEQ_RST_REF        2'h0
`define ADCSEQ_RST_SRC        3'h0

// Input source codes
`define ADCSEQ_SRC_EXT        3'h0
`define ADCSEQ_SRC_BANDGAP    3'h1
`define ADCSEQ_SRC_AMP_OUT    3'h2
`define ADCSEQ_SRC_AMP_INP    3'h3
`define ADCSEQ_SRC_GND        3'h4

// Reference code that selects the supply
`define ADCSEQ_REF_SUPPLY     2'h1

// Conversion timing in converter clocks
`define ADCSEQ_SAMPLE_CLKS    4'h4
`define ADCSEQ_CONV_CLKS      4'hc
`define ADCSEQ_TOTAL_CLKS     5'h10

// Result
`define ADCSEQ_RES_WIDTH      12
`define ADCSEQ_RES_MSB_TRIAL  12'h800

// Sequencer states
`define ADCSEQ_ST_IDLE        2'h0
`define ADCSEQ_ST_SAMPLE      2'h1
`define ADCSEQ_ST_CONVERT     2'h2

`endif

// >>> adcseq_clk_div.v
// Purpose: Converter clock divider giving one tick per 2**sel system clocks.
// Assumes: sel is stable during a conversion; clear restarts the count.
// Notes:   Tick is a one-cycle pulse; code 0 ticks on every clock.
`timescale 1ns/1ns

module adcseq_clk_div
(
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       clear,
    input  wire [2:0] sel,
    output reg        tick
);

    reg  [6:0] cnt_ff;
    reg  [6:0] nxt_cnt;
    wire [6:0] limit;

    // Terminal count is 2**sel - 1
    assign limit = (7'h7f >> (3'h7 - sel));

    // Free counter; clear aligns the first tick with the start of sampling
    always @*
    begin
        if (clear || (cnt_ff == limit))
            nxt_cnt = 7'h00;
        else
            nxt_cnt = cnt_ff + 7'h01;
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= 7'h00;
            tick   <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            // Looks at the next count so the first tick lands one period after a clear
            tick   <= (nxt_cnt == limit);
        end
    end

endmodule

// >>> adcseq_chk_asserts.sv
// Purpose: Port-level checker for the conversion sequencer.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes:   Phase lengths depend on the divider, so the bench measures them.
`timescale 1ns/1ns

module adcseq_chk
(
    input wire        ref_clk,
    input wire        rst_n,
    input wire        psel,
    input wire        penable,
    input wire [7:0]  paddr,
    input wire        pready,
    input wire        pslverr,
    input wire [11:0] dacTrial,
    input wire        convPowerOn,
    input wire        sampleActive,
    input wire        convertActive,
    input wire        extChanConnect,
    input wire [3:0]  extChanSelect,
    input wire [3:0]  internalSelect,
    input wire [1:0]  refSourceSelect,
    input wire        defaultRefDisconnect
);
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // Access phase that still waits, and the end of sampling
    sequence sAccessWait;
        psel && penable && !pready;
    endsequence
    sequence sSampleEnd;
        $fell(sampleActive);
    endsequence

    // One wait state, then a single-cycle ready
    a_pready_wait: assert property (sAccessWait |=> pready ##1 !pready)
        else $error("ready not one cycle after wait");
    a_unmapped_err: assert property (pready && paddr > 8'h18 |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (pready && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access flagged as error");
    a_phase_exclusive: assert property (!(sampleActive && convertActive))
        else $error("sample and convert overlap");
    a_sample_to_convert: assert property (sSampleEnd |-> convertActive)
        else $error("sampling not followed by conversion");
    // Past reset term: the first edge after release still shows reset values
    a_power_off_sel: assert property (!convPowerOn && $past(rst_n) |-> !extChanConnect
        && extChanSelect == 4'h0 && refSourceSelect == 2'h0 && internalSelect == 4'h0)
        else $error("selects driven while unpowered");
    a_power_off_ref: assert property (!convPowerOn && $past(rst_n) |-> defaultRefDisconnect)
        else $error("reference connected while unpowered");
    a_source_onehot: assert property ($onehot0(internalSelect)
        && !(extChanConnect && internalSelect != 4'h0))
        else $error("source selection not exclusive");
    a_trial_idle: assert property (!sampleActive && !convertActive && !$past(convertActive)
        |-> dacTrial == 12'h000)
        else $error("trial code outside conversion");
    a_trial_first: assert property ($rose(convertActive) |-> dacTrial == 12'h800)
        else $error("first trial is not mid scale");
endmodule

bind adcseq_top adcseq_chk chk_u
(
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .dacTrial(dacTrial), .convPowerOn(convPowerOn),
    .sampleActive(sampleActive), .convertActive(convertActive),
    .extChanConnect(extChanConnect), .extChanSelect(extChanSelect),
    .internalSelect(internalSelect), .refSourceSelect(refSourceSelect),
    .defaultRefDisconnect(defaultRefDisconnect)
);

// >>> tb_top.sv
// Purpose: Self-checking bench for the conversion sequencer over APB.
// Assumes: Ideal comparator; result equals the analog code.
// Notes:   Expected accesses and phase lengths are queued, a monitor compares.
`timescale 1ns/1ns
`include "adcseq_defines.vh"

module tb_top;
    reg         ref_clk = 1'b0;
    reg         rst_n = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h00000000;
    reg  [11:0] vin = 12'h000;
    wire [31:0] prdata;
    wire [11:0] dacTrial;
    wire [3:0]  extChanSelect, internalSelect;
    wire [1:0]  refSourceSelect;
    wire        pready, pslverr, cmpAbove, convPowerOn, sampleActive, convertActive;
    wire        extChanConnect, defaultRefDisconnect, irq;
    reg  [33:0] apbQ[$];
    reg  [33:0] apbE;
    int         smpQ[$], cnvQ[$];
    int         fails = 0, samples_checked = 0, sCnt = 0, cCnt = 0, cycles = 0, k;
    bit         skipOne = 0;
    reg  [31:0] rnd, c0;
    reg  [11:0] res;
    reg  [3:0]  chan;
    reg  [2:0]  src;
    reg         fmt, refoff;

    adcseq_top dut_u
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmpAbove(cmpAbove), .dacTrial(dacTrial),
        .convPowerOn(convPowerOn), .sampleActive(sampleActive),
        .convertActive(convertActive), .extChanConnect(extChanConnect),
        .extChanSelect(extChanSelect), .internalSelect(internalSelect),
        .refSourceSelect(refSourceSelect), .defaultRefDisconnect(defaultRefDisconnect),
        .irq(irq)
    );

    // Comparator is analog, so it answers within the cycle
    assign cmpAbove = (vin >= dacTrial);

    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        begin
            samples_checked++;
            if (seen !== exp)
            begin
                fails++;
                $display("ERROR %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    // One transfer; an idle edge first keeps two transfers from sharing a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic err);
        begin
            @(posedge ref_clk);
            apbQ.push_back({~wr, err, wr ? 32'h0 : d});
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge ref_clk);
            penable <= 1'b1;
            @(posedge ref_clk);
            while (pready !== 1'b1) @(posedge ref_clk);
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // The global cycle ceiling bounds these waits
    task automatic waitDone;
        begin
            wait (convertActive === 1'b1);
            wait (convertActive === 1'b0);
            repeat (3) @(posedge ref_clk);
        end
    endtask

    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", samples_checked, fails);
            if (fails == 0 && samples_checked > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    // Monitor: completed accesses, phase lengths, and the hang limit
    always @(posedge ref_clk)
    begin
        cycles++;
        if (psel && penable && pready === 1'b1)
        begin
            apbE = apbQ.pop_front();
            check("pslverr", pslverr, apbE[32]);
            if (apbE[33]) check("prdata", prdata, apbE[31:0]);
        end
        if (sampleActive === 1'b1) sCnt++;
        if (convertActive === 1'b1) cCnt++;
        else if (cCnt != 0)
        begin
            if (skipOne) skipOne = 0;
            else
            begin
                check("sample_len", sCnt, smpQ.pop_front());
                check("convert_len", cCnt, cnvQ.pop_front());
            end
            sCnt = 0;
            cCnt = 0;
        end
        if (cycles == 20000)
        begin
            fails++;
            end_of_test();
        end
    end

    initial
    begin
        void'($urandom(3393));
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(0, `ADCSEQ_OFS_CTRL0, 32'h0, 0);
        apb(0, `ADCSEQ_OFS_CTRL1, 32'h0, 0);
        apb(0, `ADCSEQ_OFS_INT_STAT, 32'h0, 0);
        apb(0, 8'h1c, 32'h0, 1);
        apb(1, 8'h20, 32'hff, 1);
        check("convPowerOn", convPowerOn, 1'b0);
        $display("test reset done");
        apb(1, `ADCSEQ_OFS_INT_GLOBAL, 32'h1, 0);
        // Every divider and source code; code 1 runs with the interrupt masked
        for (k = 0; k < 8; k++)
        begin
            rnd = $urandom;
            res = (k == 7) ? 12'hfff : rnd[11:0];
            vin <= res;
            src = k;
            fmt = k[0];
            refoff = (k[1:0] == `ADCSEQ_REF_SUPPLY);
            chan = (src >= 1 && src <= 4) ? 4'h5 + src : k[3:0];
            c0 = {26'h0, 1'b1, fmt, chan};
            apb(1, `ADCSEQ_OFS_INT_MASK, {31'h0, k != 1}, 0);
            apb(1, `ADCSEQ_OFS_CTRL0, c0, 0);
            apb(1, `ADCSEQ_OFS_CTRL1, {23'h0, refoff, src, k[1:0], src}, 0);
            repeat (2) @(posedge ref_clk);
            check("extChanConnect", extChanConnect, src == 0 || src > 4);
            check("internalSelect", internalSelect,
                  (src >= 1 && src <= 4) ? 4'h1 << (src - 1) : 4'h0);
            check("extChanSelect", extChanSelect, chan);
            check("refSourceSelect", refSourceSelect, k[1:0]);
            check("defaultRefDisconnect", defaultRefDisconnect, refoff);
            check("convPowerOn", convPowerOn, 1'b1);
            apb(1, `ADCSEQ_OFS_CTRL0, c0 | 32'h80, 0);
            apb(1, `ADCSEQ_OFS_CTRL0, c0, 0);
            smpQ.push_back(4 << k);
            cnvQ.push_back(12 << k);
            apb(0, `ADCSEQ_OFS_CTRL0, c0 | 32'h40, 0);
            waitDone();
            check("irq", irq, k != 1);
            apb(0, `ADCSEQ_OFS_CTRL0, c0, 0);
            apb(0, `ADCSEQ_OFS_RES_HIGH, fmt ? res[11:8] : res[11:4], 0);
            apb(0, `ADCSEQ_OFS_RES_LOW, fmt ? res[7:0] : {res[3:0], 4'h0}, 0);
            apb(0, `ADCSEQ_OFS_INT_STAT, 32'h1, 0);
            apb(1, `ADCSEQ_OFS_INT_STAT, 32'h1, 0);
            apb(0, `ADCSEQ_OFS_INT_STAT, 32'h0, 0);
            check("irq", irq, 1'b0);
            $display("test divider %0d done", k);
        end
        // A new start pulse in mid-conversion restarts a full conversion
        apb(1, `ADCSEQ_OFS_CTRL1, 32'h3, 0);
        apb(1, `ADCSEQ_OFS_CTRL0, 32'ha0, 0);
        apb(1, `ADCSEQ_OFS_CTRL0, 32'h20, 0);
        wait (convertActive === 1'b1);
        skipOne = 1;
        apb(1, `ADCSEQ_OFS_CTRL0, 32'ha0, 0);
        apb(1, `ADCSEQ_OFS_CTRL0, 32'h20, 0);
        smpQ.push_back(32);
        cnvQ.push_back(96);
        waitDone();
        apb(1, `ADCSEQ_OFS_INT_STAT, 32'h1, 0);
        $display("test restart done");
        // Power removed in mid-conversion: no completion
        apb(1, `ADCSEQ_OFS_CTRL0, 32'ha0, 0);
        apb(1, `ADCSEQ_OFS_CTRL0, 32'h20, 0);
        wait (convertActive === 1'b1);
        skipOne = 1;
        apb(1, `ADCSEQ_OFS_CTRL0, 32'h00, 0);
        repeat (200) @(posedge ref_clk);
        check("convPowerOn", convPowerOn, 1'b0);
        apb(0, `ADCSEQ_OFS_CTRL0, 32'h0, 0);
        apb(0, `ADCSEQ_OFS_INT_STAT, 32'h0, 0);
        $display("test power off done");
        end_of_test();
    end
endmodule
